// ===== fcp_cfg.svh
// Register indices, field positions, reset values and bus codes of the PWM block
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
`define FCP_IDX_CLK 10'h040
`define FCP_IDX_POL 10'h041
`define FCP_IDX_EN 10'h042
`define FCP_IDX_PRES 10'h043
`define FCP_IDX_SCAL0 10'h044
`define FCP_IDX_SCNT0 10'h045
`define FCP_IDX_SCAL1 10'h046
`define FCP_IDX_SCNT1 10'h047
`define FCP_IDX_CNT0 10'h048
`define FCP_IDX_PER0 10'h04c
`define FCP_IDX_DTY0 10'h050
`define FCP_IDX_CTL 10'h054
`define FCP_IDX_TST 10'h055
`define FCP_IDX_MODE 10'h056
`define FCP_IDX_DDR 10'h057
`define FCP_BIT_JOIN_HI 7
`define FCP_BIT_JOIN_LO 6
`define FCP_BIT_CENTER 3
`define FCP_BIT_NO_SCALE_LOAD 2
`define FCP_BIT_NO_PERIOD_RESET 1
`define FCP_BIT_NO_COUNTER_CLEAR 0
`define FCP_RST_PER 8'hff
`define FCP_RST_DTY 8'hff
`define FCP_RST_REG 8'h00
`define FCP_RESP_OKAY 2'b00
`define FCP_RESP_SLVERR 2'b10
`endif

// ===== fcp_pkg.sv
// Types shared by the PWM block modules
`default_nettype none
package fcp_pkg;
   typedef struct packed {
      logic [1:0][7:0] cnt;
      logic [1:0][7:0] per_buf;
      logic [1:0][7:0] per_act;
      logic [1:0][7:0] dty_buf;
      logic [1:0][7:0] dty_act;
      logic [1:0] dn;
      logic [1:0] run;
      logic [1:0] out;
   } fcp_pair_s;
   typedef struct packed {
      logic [7:0] cnt;
      logic half;
   } fcp_scl_s;
   typedef struct packed {
      logic [7:0] clk_cfg;
      logic [7:0] sel_pol;
      logic [3:0] en;
      logic [6:0] pres;
      logic [1:0][7:0] scal;
      logic center;
      logic [2:0] tst;
      logic special;
      logic [7:0] ddr;
      logic aw_got;
      logic [11:0] awaddr;
      logic w_got;
      logic [7:0] wdat;
      logic wlane;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [3:0] pin;
      logic [3:0] pin_oe_n;
   } fcp_top_s;
endpackage
`default_nettype wire

// ===== fcp_pair_if.sv
// Control and status bundle between the top and one channel pair
`default_nettype none
interface fcp_pair_if;
   logic [1:0] tick;
   logic [1:0] en;
   logic [1:0] pol;
   logic [1:0] wr_cnt;
   logic [1:0] wr_per;
   logic [1:0] wr_dty;
   logic [1:0] out;
   logic join_pair;
   logic center;
   logic no_clr;
   logic no_per;
   logic [7:0] wdata;
   logic [1:0][7:0] cnt;
   logic [1:0][7:0] per;
   logic [1:0][7:0] dty;
   modport ctl(output tick, en, pol, wr_cnt, wr_per, wr_dty, join_pair, center, no_clr,
      no_per, wdata, input out, cnt, per, dty);
   modport unit(input tick, en, pol, wr_cnt, wr_per, wr_dty, join_pair, center, no_clr,
      no_per, wdata, output out, cnt, per, dty);
endinterface
`default_nettype wire

// ===== fcp_scaler.sv
// Scale down-counter making one scaled clock tick
`default_nettype none
module fcp_scaler
   import fcp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tick_in,
   input wire logic load,
   input wire logic [7:0] scale,
   output logic [7:0] count,
   output logic tick_out
);
   fcp_scl_s s;
   fcp_scl_s n;

   always_comb begin
      n = s;
      if (tick_in) begin
         if (s.cnt == 8'h00) begin
            n.cnt = scale;
            n.half = ~s.half;
         end else begin
            n.cnt = s.cnt - 8'h01;
         end
      end
      if (load) begin
         n.cnt = scale;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign count = s.cnt;
   assign tick_out = tick_in & (s.cnt == 8'h00) & s.half;
endmodule
`default_nettype wire

// ===== fcp_pair.sv
// Two 8-bit PWM channels that can be joined into one 16-bit channel
`default_nettype none
`include "fcp_cfg.svh"
module fcp_pair
   import fcp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   fcp_pair_if.unit p
);
   fcp_pair_s s;
   fcp_pair_s n;

   // Returns {rollover, down, count}
   function automatic logic [17:0] step(input logic [15:0] c, input logic [15:0] pv,
      input logic dn, input logic ctr, input logic hold);
      logic [17:0] r;
      r = {1'b0, dn, 16'(c + 16'h0001)};
      if (!ctr) begin
         if (c == pv && !hold) begin
            r = {2'b10, 16'h0000};
         end
      end else if (!dn) begin
         if (c >= pv) begin
            r = (pv == 16'h0000) ? {2'b10, 16'h0000} : {2'b01, 16'(c - 16'h0001)};
         end
      end else if (c == 16'h0000) begin
         r = {2'b10, (pv == 16'h0000) ? 16'h0000 : 16'h0001};
      end else begin
         r = {2'b01, 16'(c - 16'h0001)};
      end
      return r;
   endfunction

   always_comb begin
      logic [15:0] cv;
      logic [15:0] pv;
      logic [15:0] dv;
      logic [17:0] st;
      logic j;
      logic tk;
      logic act;
      n = s;
      cv = '0;
      pv = '0;
      dv = '0;
      st = '0;
      tk = 1'b0;
      act = 1'b0;
      j = p.join_pair;
      for (int k = 0; k < 2; k++) begin
         if (p.wr_per[k]) begin
            n.per_buf[k] = p.wdata;
         end
         if (p.wr_dty[k]) begin
            n.dty_buf[k] = p.wdata;
         end
         if (!((j && k == 1) ? p.en[0] : p.en[k])) begin
            n.per_act[k] = n.per_buf[k];
            n.dty_act[k] = n.dty_buf[k];
         end
      end
      for (int u = 0; u < 2; u++) begin
         if (!(j && u == 1)) begin
            if (j) begin
               cv = {s.cnt[0], s.cnt[1]};
               pv = {s.per_act[0], s.per_act[1]};
               dv = {s.dty_act[0], s.dty_act[1]};
               tk = p.tick[1];
            end else begin
               cv = {8'h00, s.cnt[u]};
               pv = {8'h00, s.per_act[u]};
               dv = {8'h00, s.dty_act[u]};
               tk = p.tick[u];
            end
            if (tk) begin
               n.run[u] = p.en[u];
            end
            if (tk && s.run[u]) begin
               st = step(cv, pv, s.dn[u], p.center, p.no_per);
               n.dn[u] = st[16];
               if (j) begin
                  n.cnt[0] = st[15:8];
                  n.cnt[1] = st[7:0];
               end else begin
                  n.cnt[u] = st[7:0];
               end
               if (st[17]) begin
                  n.per_act[u] = n.per_buf[u];
                  n.dty_act[u] = n.dty_buf[u];
                  if (j) begin
                     n.per_act[1] = n.per_buf[1];
                     n.dty_act[1] = n.dty_buf[1];
                  end
               end
            end
            act = p.center ? (cv >= dv) : (cv > dv);
            // No change when duty reaches period
            n.out[u] = (dv >= pv) ? p.pol[u] : (p.pol[u] ^ act);
         end else begin
            n.out[u] = p.pol[u];
            n.run[u] = 1'b0;
         end
      end
      for (int k = 0; k < 2; k++) begin
         if (p.wr_cnt[k]) begin
            if (!p.no_clr) begin
               n.cnt[k] = 8'h00;
            end
            n.dn[k] = 1'b0;
            n.per_act[k] = n.per_buf[k];
            n.dty_act[k] = n.dty_buf[k];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s.cnt <= '0;
         s.per_buf <= {2{`FCP_RST_PER}};
         s.per_act <= {2{`FCP_RST_PER}};
         s.dty_buf <= {2{`FCP_RST_DTY}};
         s.dty_act <= {2{`FCP_RST_DTY}};
         s.dn <= '0;
         s.run <= '0;
         s.out <= '0;
      end else begin
         s <= n;
      end
   end

   assign p.cnt = s.cnt;
   assign p.per = s.per_buf;
   assign p.dty = s.dty_buf;
   assign p.out = s.out;
endmodule
`default_nettype wire

// ===== fcp_top.sv
// Four-channel PWM block with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
`include "fcp_cfg.svh"
module fcp_top
   import fcp_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [3:0] PWM_PIN,
   output logic [3:0] PWM_PIN_OE_N
);
   fcp_top_s s;
   fcp_top_s n;
   fcp_pair_if pr0();
   fcp_pair_if pr1();
   logic [1:0][7:0] scnt;
   logic [1:0] stick;
   logic [6:0] mask_a;
   logic [6:0] mask_b;
   logic run_any;
   logic tick_a;
   logic tick_b;
   logic wr_go;
   logic [9:0] widx;
   logic [3:0] tick_ch;
   logic [3:0] pwm_out;
   logic [3:0][7:0] cnt_all;
   logic [3:0][7:0] per_all;
   logic [3:0][7:0] dty_all;
   logic tst_ok;

   function automatic logic mapped(input logic [9:0] idx);
      return (idx >= `FCP_IDX_CLK && idx <= `FCP_IDX_DDR);
   endfunction

   function automatic logic wsel(input logic go, input logic lane, input logic [9:0] idx,
      input logic [9:0] want);
      return go & lane & (idx == want);
   endfunction

   assign run_any = |s.en;
   assign mask_a = 7'h7f >> (3'd7 - s.clk_cfg[5:3]);
   assign mask_b = 7'h7f >> (3'd7 - s.clk_cfg[2:0]);
   // Branch tick every 2^n bus clocks
   assign tick_a = run_any & ((s.pres & mask_a) == mask_a);
   assign tick_b = run_any & ((s.pres & mask_b) == mask_b);
   assign wr_go = s.aw_got & s.w_got & ~s.bvalid;
   assign widx = s.awaddr[11:2];
   assign tst_ok = s.special;

   assign tick_ch[0] = s.sel_pol[4] ? stick[0] : tick_a;
   assign tick_ch[1] = s.sel_pol[5] ? stick[0] : tick_a;
   assign tick_ch[2] = s.sel_pol[6] ? stick[1] : tick_b;
   assign tick_ch[3] = s.sel_pol[7] ? stick[1] : tick_b;

   fcp_scaler u_scl0 (
      .clk(CLOCK),
      .rst(RST),
      .tick_in(tick_a),
      .load(wsel(wr_go, s.wlane, widx, `FCP_IDX_SCAL0) &
         ~(tst_ok & s.tst[`FCP_BIT_NO_SCALE_LOAD])),
      .scale(wsel(wr_go, s.wlane, widx, `FCP_IDX_SCAL0) ? s.wdat : s.scal[0]),
      .count(scnt[0]),
      .tick_out(stick[0])
   );

   fcp_scaler u_scl1 (
      .clk(CLOCK),
      .rst(RST),
      .tick_in(tick_b),
      .load(wsel(wr_go, s.wlane, widx, `FCP_IDX_SCAL1) &
         ~(tst_ok & s.tst[`FCP_BIT_NO_SCALE_LOAD])),
      .scale(wsel(wr_go, s.wlane, widx, `FCP_IDX_SCAL1) ? s.wdat : s.scal[1]),
      .count(scnt[1]),
      .tick_out(stick[1])
   );

   // Pair 0/1: high byte is channel 0
   assign pr0.join_pair = s.clk_cfg[`FCP_BIT_JOIN_LO];
   // Pair 2/3: high byte is channel 2
   assign pr1.join_pair = s.clk_cfg[`FCP_BIT_JOIN_HI];
   assign pr0.center = s.center;
   assign pr1.center = s.center;
   assign pr0.no_clr = tst_ok & s.tst[`FCP_BIT_NO_COUNTER_CLEAR];
   assign pr1.no_clr = tst_ok & s.tst[`FCP_BIT_NO_COUNTER_CLEAR];
   assign pr0.no_per = tst_ok & s.tst[`FCP_BIT_NO_PERIOD_RESET];
   assign pr1.no_per = tst_ok & s.tst[`FCP_BIT_NO_PERIOD_RESET];
   assign pr0.wdata = s.wdat;
   assign pr1.wdata = s.wdat;
   assign pr0.tick = tick_ch[1:0];
   assign pr1.tick = tick_ch[3:2];
   assign pr0.en = s.en[1:0];
   assign pr1.en = s.en[3:2];
   assign pr0.pol = s.sel_pol[1:0];
   assign pr1.pol = s.sel_pol[3:2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_wr
         assign pr0.wr_cnt[g] = wsel(wr_go, s.wlane, widx, `FCP_IDX_CNT0 + 10'(g));
         assign pr1.wr_cnt[g] = wsel(wr_go, s.wlane, widx, `FCP_IDX_CNT0 + 10'(g + 2));
         assign pr0.wr_per[g] = wsel(wr_go, s.wlane, widx, `FCP_IDX_PER0 + 10'(g));
         assign pr1.wr_per[g] = wsel(wr_go, s.wlane, widx, `FCP_IDX_PER0 + 10'(g + 2));
         assign pr0.wr_dty[g] = wsel(wr_go, s.wlane, widx, `FCP_IDX_DTY0 + 10'(g));
         assign pr1.wr_dty[g] = wsel(wr_go, s.wlane, widx, `FCP_IDX_DTY0 + 10'(g + 2));
      end
   endgenerate

   fcp_pair u_pair0 (
      .clk(CLOCK),
      .rst(RST),
      .p(pr0)
   );

   fcp_pair u_pair1 (
      .clk(CLOCK),
      .rst(RST),
      .p(pr1)
   );

   assign pwm_out = {pr1.out, pr0.out};
   assign cnt_all = {pr1.cnt, pr0.cnt};
   assign per_all = {pr1.per, pr0.per};
   assign dty_all = {pr1.dty, pr0.dty};

   always_comb begin
      logic [9:0] ridx;
      logic [7:0] rd;
      n = s;
      ridx = S_AXI_ARADDR[11:2];
      rd = 8'h00;
      if (run_any) begin
         n.pres = s.pres + 7'h01;
      end
      // Test bits clear outside special mode
      if (!s.special) begin
         n.tst = 3'b000;
      end
      if (S_AXI_AWVALID && s.awready) begin
         n.aw_got = 1'b1;
         n.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s.wready) begin
         n.w_got = 1'b1;
         n.wdat = S_AXI_WDATA[7:0];
         n.wlane = S_AXI_WSTRB[0];
      end
      if (s.bvalid && S_AXI_BREADY) begin
         n.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = mapped(widx) ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
         if (s.wlane) begin
            unique case (widx)
               `FCP_IDX_CLK: n.clk_cfg = s.wdat;
               `FCP_IDX_POL: n.sel_pol = s.wdat;
               `FCP_IDX_EN: n.en = s.wdat[3:0];
               // Prescaler writable only in special mode
               `FCP_IDX_PRES: n.pres = s.special ? s.wdat[6:0] : n.pres;
               `FCP_IDX_SCAL0: n.scal[0] = s.wdat;
               `FCP_IDX_SCAL1: n.scal[1] = s.wdat;
               `FCP_IDX_CTL: n.center = s.wdat[`FCP_BIT_CENTER];
               `FCP_IDX_TST: n.tst = s.special ? s.wdat[2:0] : n.tst;
               `FCP_IDX_MODE: n.special = s.wdat[0];
               `FCP_IDX_DDR: n.ddr = s.wdat;
               default: n.ddr = s.ddr;
            endcase
         end
      end
      if (s.rvalid && S_AXI_RREADY) begin
         n.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && s.arready) begin
         unique case (ridx)
            `FCP_IDX_CLK: rd = s.clk_cfg;
            `FCP_IDX_POL: rd = s.sel_pol;
            `FCP_IDX_EN: rd = {4'h0, s.en};
            `FCP_IDX_PRES: rd = {1'b0, s.pres};
            `FCP_IDX_SCAL0: rd = s.scal[0];
            `FCP_IDX_SCNT0: rd = scnt[0];
            `FCP_IDX_SCAL1: rd = s.scal[1];
            `FCP_IDX_SCNT1: rd = scnt[1];
            `FCP_IDX_CTL: rd = {4'h0, s.center, 3'b000};
            `FCP_IDX_TST: rd = {5'h00, s.tst};
            `FCP_IDX_MODE: rd = {7'h00, s.special};
            `FCP_IDX_DDR: rd = s.ddr;
            default: rd = 8'h00;
         endcase
         for (int k = 0; k < 4; k++) begin
            if (ridx == `FCP_IDX_CNT0 + 10'(k)) rd = cnt_all[k];
            if (ridx == `FCP_IDX_PER0 + 10'(k)) rd = per_all[k];
            if (ridx == `FCP_IDX_DTY0 + 10'(k)) rd = dty_all[k];
         end
         n.rvalid = 1'b1;
         n.rdata = rd;
         n.rresp = mapped(ridx) ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
      end
      n.awready = ~n.aw_got & ~n.bvalid;
      n.wready = ~n.w_got & ~n.bvalid;
      n.arready = ~n.rvalid;
      for (int k = 0; k < 4; k++) begin
         n.pin_oe_n[k] = ~(s.en[k] | s.ddr[k]);
         n.pin[k] = s.en[k] & pwm_out[k];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         s <= '0;
         s.pin_oe_n <= 4'hf;
      end else begin
         s <= n;
      end
   end

   assign S_AXI_AWREADY = s.awready;
   assign S_AXI_WREADY = s.wready;
   assign S_AXI_BRESP = s.bresp;
   assign S_AXI_BVALID = s.bvalid;
   assign S_AXI_ARREADY = s.arready;
   assign S_AXI_RDATA = {24'h000000, s.rdata};
   assign S_AXI_RRESP = s.rresp;
   assign S_AXI_RVALID = s.rvalid;
   assign PWM_PIN = s.pin;
   assign PWM_PIN_OE_N = s.pin_oe_n;
endmodule
`default_nettype wire

// ===== fcp_load.sv
// Loads on the four shared pins, timing each waveform they see
`default_nettype none
module fcp_load (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] pin,
   input wire logic [3:0] pin_oe_n,
   output logic [3:0][15:0] period,
   output logic [3:0][15:0] high
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lvl;
   logic [3:0] last;
   logic [3:0][15:0] run;
   logic [3:0][15:0] hrun;
   // No pull on these pins: a released pin shows the inverse of its last level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lvl[i] = pin_oe_n[i] ? ~last[i] : pin[i];
      end
   end
   // Period and high time, both counted from one rising edge to the next
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last <= '0;
         run <= '0;
         hrun <= '0;
         period <= '0;
         high <= '0;
      end else begin
         last <= lvl;
         for (int i = 0; i < 4; i++) begin
            if (lvl[i] && !last[i]) begin
               period[i] <= run[i];
               high[i] <= hrun[i];
               run[i] <= 16'h0001;
               hrun[i] <= 16'h0001;
            end else begin
               run[i] <= run[i] + 16'h0001;
               hrun[i] <= hrun[i] + {15'h0000, lvl[i]};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== fcp_top_monitor.sv
// Bus handshake and pin checks on the PWM block top ports
`default_nettype none
module fcp_top_monitor (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [3:0] PWM_PIN,
   input wire logic [3:0] PWM_PIN_OE_N
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
   write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
      S_AXI_WREADY |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer late");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("address taken during read answer");
   write_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken during write answer");
   unmapped_write_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
      S_AXI_WREADY && (S_AXI_AWADDR < 12'h100 || S_AXI_AWADDR > 12'h15f)
      |-> ##2 S_AXI_BRESP == 2'b10) else $error("unmapped write not refused");
   unmapped_read_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
      (S_AXI_ARADDR < 12'h100 || S_AXI_ARADDR > 12'h15f)
      |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0) else $error("unmapped read");
   rdata_width_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
      else $error("read data upper bits set");
   idle_pin_a: assert property (PWM_PIN_OE_N == 4'hf |-> PWM_PIN == 4'h0)
      else $error("released pin driven high");
endmodule
bind fcp_top fcp_top_monitor fcp_top_monitor_i (.CLOCK(CLOCK), .RST(RST),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .PWM_PIN(PWM_PIN),
   .PWM_PIN_OE_N(PWM_PIN_OE_N));
`default_nettype wire

// ===== four_channel_pwm_tb_top.sv
// Self-checking bench for the four-channel PWM block
`default_nettype none
`include "fcp_cfg.svh"
module four_channel_pwm_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] okay = `FCP_RESP_OKAY;
   localparam logic [1:0] bad = `FCP_RESP_SLVERR;
   logic clock, rst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, pin, pin_oe_n;
   logic [1:0] bresp, rresp;
   logic [3:0][15:0] per_seen, high_seen;
   int fails, check_count, seed;
   fcp_top fcp_top_i (.CLOCK(clock), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .PWM_PIN(pin), .PWM_PIN_OE_N(pin_oe_n));
   fcp_load fcp_load_i (.clk(clock), .rst(rst), .pin(pin), .pin_oe_n(pin_oe_n),
      .period(per_seen), .high(high_seen));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   function automatic int t_len(int n, int sel, int s);
      return (1 << n) * (sel != 0 ? 2 * (s + 1) : 1);
   endfunction
   function automatic int e_high(int per, int dty, int pol, int t);
      return t * (pol != 0 ? dty + 1 : per - dty);
   endfunction
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clock);
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {$random(seed)} & 32'hffffff00 | {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if ((bvalid && bready) || n > 50) break;
      end
      check(n <= 50 && bresp === er, "write answer");
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] idx, output logic [7:0] d, output logic [1:0] r);
      int n;
      @(posedge clock);
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if ((rvalid && rready) || n > 50) break;
      end
      d = rdata[7:0];
      r = n > 50 ? 2'bxx : rresp;
      rready <= 1'b0;
   endtask
   task automatic rdc(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
      logic [7:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      check(d === e && r === er, "read value");
   endtask
   task automatic arm(input int ch, input int per, input int dty, input logic [7:0] en);
      wr(`FCP_IDX_PER0 + ch[9:0], per[7:0], okay);
      wr(`FCP_IDX_DTY0 + ch[9:0], dty[7:0], okay);
      wr(`FCP_IDX_CNT0 + ch[9:0], 8'h00, okay);
      wr(`FCP_IDX_EN, en, okay);
   endtask
   task automatic meas(input int ch, input int ep, input int eh);
      logic [7:0] d;
      logic [1:0] r;
      // Counter reads while the channel runs must leave the waveform alone
      repeat (ep + 20) rd(`FCP_IDX_CNT0 + ch[9:0], d, r);
      check(per_seen[ch] === ep[15:0], "period length");
      if (eh > 0) check(high_seen[ch] === eh[15:0], "high time");
   endtask
   task automatic final_report;
      if (fails == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clock);
      fails++;
      final_report;
   end
   initial begin
      int ch, sel, pol, n, s, per, dty;
      logic [7:0] v, a;
      logic [1:0] r;
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h3f & 6'h20;
      {awaddr, araddr, wdata, wstrb} = '0;
      fails = 0;
      check_count = 0;
      seed = 32'h7659;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rdc(`FCP_IDX_CLK, 8'h00, okay);
      rdc(`FCP_IDX_EN, 8'h00, okay);
      for (int i = 0; i < 4; i++) begin
         rdc(`FCP_IDX_PER0 + i[9:0], 8'hff, okay);
         rdc(`FCP_IDX_DTY0 + i[9:0], 8'hff, okay);
      end
      wr(10'h058, 8'h5a, bad);
      rdc(10'h03f, 8'h00, bad);
      rd(`FCP_IDX_PRES, a, r);
      wr(`FCP_IDX_PRES, 8'h33, okay);
      rdc(`FCP_IDX_PRES, a, okay); // stopped, write ignored
      wr(`FCP_IDX_SCAL0, 8'h30, okay);
      rdc(`FCP_IDX_SCNT0, 8'h30, okay); // load on write
      wr(`FCP_IDX_DDR, 8'h02, okay);
      repeat (3) @(posedge clock);
      check(pin_oe_n === 4'b1101, "direction bit"); // direction bit rules
      for (int k = 0; k < 8; k++) begin
         ch = (k * 3) % 4;
         sel = k >= 6;
         pol = k / 4;
         n = $unsigned($random(seed)) % 3;
         s = $unsigned($random(seed)) % 3;
         per = 4 + $unsigned($random(seed)) % 28;
         dty = $unsigned($random(seed)) % per;
         v = 8'h00;
         v[4 + ch] = sel[0];
         v[3:0] = {4{pol[0]}};
         wr(`FCP_IDX_CLK, {2'b00, n[2:0], n[2:0]}, okay);
         wr(`FCP_IDX_POL, v, okay);
         wr(ch < 2 ? `FCP_IDX_SCAL0 : `FCP_IDX_SCAL1, s[7:0], okay);
         arm(ch, per, dty, 8'h01 << ch);
         repeat (3) @(posedge clock);
         check(pin_oe_n[ch] === 1'b0, "enable drives pin");
         meas(ch, (per + 1) * t_len(n, sel, s), e_high(per, dty, pol, t_len(n, sel, s)));
         wr(`FCP_IDX_EN, 8'h00, okay);
         repeat (3) @(posedge clock);
         check(pin_oe_n[ch] === (ch != 1), "pin released");
      end
      rdc(`FCP_IDX_DDR, 8'h02, okay); // direction bit kept
      wr(`FCP_IDX_POL, 8'h0f, okay);
      wr(`FCP_IDX_CLK, 8'h00, okay);
      arm(0, 5, 5, 8'h01);
      repeat (10) @(posedge clock);
      repeat (20) @(posedge clock) check(pin[0] === 1'b1, "duty at period");
      wr(`FCP_IDX_EN, 8'h00, okay);
      wr(`FCP_IDX_POL, 8'h00, okay);
      wr(`FCP_IDX_CTL, 8'h08, okay);
      arm(0, 6, 2, 8'h01);
      meas(0, 12, 0); // up-down period
      wr(`FCP_IDX_EN, 8'h00, okay);
      wr(`FCP_IDX_CTL, 8'h00, okay);
      for (int j = 0; j < 4; j += 2) begin
         wr(`FCP_IDX_CLK, j == 0 ? 8'h40 : 8'h80, okay);
         // Wrong select on the high channel would slow the pair a lot
         wr(`FCP_IDX_POL, 8'h10 << j, okay);
         wr(j == 0 ? `FCP_IDX_SCAL0 : `FCP_IDX_SCAL1, 8'h40, okay);
         arm(j + 1, 2, 8'h40, 8'h00);
         arm(j, 1, 0, 8'h01 << j);
         meas(j, 259, 194);
         wr(`FCP_IDX_EN, 8'h00, okay);
      end
      wr(`FCP_IDX_CLK, 8'h00, okay);
      for (int m = 0; m < 2; m++) begin
         wr(`FCP_IDX_MODE, m[7:0], okay);
         wr(`FCP_IDX_TST, m != 0 ? 8'h05 : 8'h00, okay);
         arm(3, 255, 128, 8'h08);
         repeat (100) @(posedge clock);
         wr(`FCP_IDX_EN, 8'h00, okay);
         repeat (4) @(posedge clock);
         rd(`FCP_IDX_CNT0 + 10'h003, a, r);
         wr(`FCP_IDX_CNT0 + 10'h003, 8'h55, okay);
         rdc(`FCP_IDX_CNT0 + 10'h003, m != 0 ? a : 8'h00, okay);
      end
      rd(`FCP_IDX_SCNT0, a, r);
      wr(`FCP_IDX_SCAL0, 8'h10, okay);
      rdc(`FCP_IDX_SCNT0, a, okay); // load held off
      final_report;
   end
endmodule
`default_nettype wire
